// ===== hw/bfs_top.sv
// Buck converter supervisor: gate control, fault handling, power-good.
// Assumes comparator flags arrive asynchronously from the analog side
// and software sets up the switching period over AXI4-Lite.
//
// Overview of operation
// - Enable low tristates both gate drivers.
// - Soft-start pulled low stops switching until released.
// - Sense node below ground latches over-current, hiccup.
// - Hiccup discharges soft-start for 4096 switching cycles.
// - Hiccup repeats while the overload persists.
// - Blank over-current sampling 160 ns after low gate.
// - Over-temperature turns switches off, discharges soft-start.
// - Restart automatically after cooling below hysteresis band.
// - Power-good only with feedback inside window.
// - Power-good is open drain, external pull-up.
// - Non-tracking: power-good waits for soft-start threshold.
// - Power-good rises 256 cycles after window entry.
// - Tracking low follows input, else internal reference.
// - Fixed off-time caps duty each switching cycle.
// - Switching period programmable over 250 to 1200 kHz.
// - Ready only with bias and enable good.
`timescale 1ns/1ps
module bfs_top
  import bfs_pkg::*;
#(
  parameter int HICCUP_N = HICCUP_CYCLES,
  parameter int PG_DELAY_N = PG_DELAY_CYCLES
) (
  input wire logic core_clk, // 125 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic [bfs_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [bfs_pkg::AXI_DATA_W-1:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [bfs_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [bfs_pkg::AXI_DATA_W-1:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic bias_ok, // bias above lockout
  input wire logic enable_ok, // enable above threshold
  input wire logic ss_shutdown_low, // soft-start below shutdown level
  input wire logic ocset_below_gnd, // current sense under ground
  input wire logic ls_gate_high, // low-side gate above 3 V
  input wire logic temp_trip, // temperature above trip
  input wire logic temp_cool, // temperature below trip minus hysteresis
  input wire logic feedback_input_high, // feedback above upper window
  input wire logic feedback_input_low, // feedback below lower window
  input wire logic ss_pg_ready, // soft-start above power-good delay level
  input wire logic track_handover, // tracking input above hand-over
  input wire logic power_good_out_i, // power-good pin level
  output logic power_good_out_o, // power-good pin drive value
  output logic power_good_out_oe, // power-good pulls low when high
  output logic undervoltage_lockout, // ready to run, high when released
  output logic drv_tristate, // both gate drivers tristated
  output logic hs_gate, // high-side gate command
  output logic ls_gate, // low-side gate command
  output logic ss_discharge, // short soft-start capacitor
  output logic ref_internal, // internal reference selected
  output logic overcurrent_fault // latched over-current
);
  localparam int HIC_W = $clog2(HICCUP_N + 1);
  localparam int PGD_W = $clog2(PG_DELAY_N + 1);

  // Word update honouring byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  logic [FLG_N-1:0] flg;
  bfs_sync #(.W(FLG_N)) u_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .d({power_good_out_i, track_handover, ss_pg_ready, feedback_input_low,
        feedback_input_high, temp_cool, temp_trip, ls_gate_high, ocset_below_gnd,
        ss_shutdown_low, enable_ok, bias_ok}),
    .q(flg)
  );

  // Register file
  logic ctrl_en_reg, ctrl_en_next;
  logic [PER_W-1:0] period_reg, period_next;
  logic [PER_W-1:0] ontime_reg, ontime_next;
  logic awready_next, wready_next, bvalid_next, arready_next, rvalid_next;
  logic [1:0] bresp_next, rresp_next;
  logic [31:0] rdata_next, wr_word;
  logic [AXI_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;

  // Protection state
  bfs_state_type state_reg, state_next;
  logic ocp_reg, ocp_next;
  logic pg_reg, pg_next;
  logic [PER_W-1:0] cyc_reg, cyc_next;
  logic tick_reg, tick_next;
  logic [BLANK_W-1:0] blank_reg, blank_next;
  logic hs_next, ls_next, tri_next, ssd_next, ref_next, por_next;
  logic [HIC_W-1:0] hic_count;
  logic hic_done;
  logic [PGD_W-1:0] pgd_count;
  logic pgd_done;
  logic por, pg_cond, run, ocp_sample;
  logic [PER_W-1:0] on_max, on_eff;

  always_comb begin
    awready_next = s_axi_awready;
    wready_next = s_axi_wready;
    bvalid_next = s_axi_bvalid;
    bresp_next = s_axi_bresp;
    arready_next = s_axi_arready;
    rvalid_next = s_axi_rvalid;
    rresp_next = s_axi_rresp;
    rdata_next = s_axi_rdata;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    ctrl_en_next = ctrl_en_reg;
    period_next = period_reg;
    ontime_next = ontime_reg;
    wr_word = '0;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_next = s_axi_awaddr;
      awready_next = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      wready_next = 1'b0;
    end
    // Both halves held: commit once, then answer
    if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
      bvalid_next = 1'b1;
      bresp_next = RESP_OKAY;
      if (awaddr_reg == OFS_CTRL) begin
        wr_word = merge({31'h0000_0000, ctrl_en_reg}, wdata_reg, wstrb_reg);
        ctrl_en_next = wr_word[0];
      end else if (awaddr_reg == OFS_PERIOD) begin
        wr_word = merge({20'h0_0000, period_reg}, wdata_reg, wstrb_reg);
        period_next = wr_word[PER_W-1:0];
        if (wr_word > {20'h0_0000, PERIOD_MAX}) period_next = PERIOD_MAX;
        if (wr_word < {20'h0_0000, PERIOD_MIN}) period_next = PERIOD_MIN;
      end else if (awaddr_reg == OFS_ONTIME) begin
        wr_word = merge({20'h0_0000, ontime_reg}, wdata_reg, wstrb_reg);
        ontime_next = (wr_word[31:PER_W] != 20'h0_0000) ? {PER_W{1'b1}} :
                      wr_word[PER_W-1:0];
      end else if (awaddr_reg != OFS_STATUS && awaddr_reg != OFS_COUNT) begin
        bresp_next = RESP_SLVERR;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_next = 1'b0;
      awready_next = 1'b1;
      wready_next = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      arready_next = 1'b0;
      rvalid_next = 1'b1;
      rresp_next = RESP_OKAY;
      if (s_axi_araddr == OFS_CTRL) begin
        rdata_next = {31'h0000_0000, ctrl_en_reg};
      end else if (s_axi_araddr == OFS_PERIOD) begin
        rdata_next = {20'h0_0000, period_reg};
      end else if (s_axi_araddr == OFS_ONTIME) begin
        rdata_next = {20'h0_0000, ontime_reg};
      end else if (s_axi_araddr == OFS_STATUS) begin
        rdata_next = {12'h000, flg, pg_reg, ocp_reg, por, state_reg};
      end else if (s_axi_araddr == OFS_COUNT) begin
        rdata_next = {16'(hic_count), 16'(pgd_count)};
      end else begin
        rdata_next = '0;
        rresp_next = RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_next = 1'b0;
      arready_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= 4'h0;
      ctrl_en_reg <= 1'b1;
      period_reg <= PERIOD_RST;
      ontime_reg <= ONTIME_RST;
    end else begin
      s_axi_awready <= awready_next;
      s_axi_wready <= wready_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= arready_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rresp <= rresp_next;
      s_axi_rdata <= rdata_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      ctrl_en_reg <= ctrl_en_next;
      period_reg <= period_next;
      ontime_reg <= ontime_next;
    end
  end

  assign por = flg[FLG_BIAS] && flg[FLG_EN];
  assign run = (state_reg == ST_RUN);
  assign on_max = period_reg - OFF_CYC_W;
  assign on_eff = (ontime_reg > on_max) ? on_max : ontime_reg;
  // Sampling only after the low gate has been high past the blanking time
  assign ocp_sample = flg[FLG_LS_HIGH] && (blank_reg == BLANK_CYC_W) && flg[FLG_OCSET];
  // Tracking start-up skips the soft-start threshold check
  assign pg_cond = run && !flg[FLG_FB_HI] && !flg[FLG_FB_LO]
                   && (!flg[FLG_TRACK] || flg[FLG_SS_PG]);

  // Hiccup length counted in switching cycles
  bfs_count #(.W(HIC_W), .LIMIT(HICCUP_N)) u_hiccup (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clr(state_reg != ST_HICCUP),
    .tick(tick_reg),
    .count(hic_count),
    .done(hic_done)
  );

  bfs_count #(.W(PGD_W), .LIMIT(PG_DELAY_N)) u_pg_delay (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clr(!pg_cond),
    .tick(tick_reg),
    .count(pgd_count),
    .done(pgd_done)
  );

  always_comb begin
    state_next = state_reg;
    cyc_next = (cyc_reg >= period_reg - 1'b1) ? '0 : cyc_reg + 1'b1;
    tick_next = (cyc_reg >= period_reg - 1'b1);
    blank_next = !flg[FLG_LS_HIGH] ? '0 :
                 (blank_reg == BLANK_CYC_W) ? blank_reg : blank_reg + 1'b1;
    ocp_next = ocp_reg;
    if (!por || hic_done) ocp_next = 1'b0;
    if (por && run && ocp_sample) ocp_next = 1'b1;
    case (state_reg)
      ST_OFF: if (por && ctrl_en_reg) state_next = ST_RUN;
      ST_RUN: begin
        if (ocp_reg) state_next = ST_HICCUP;
        else if (flg[FLG_SS_LOW]) state_next = ST_SSHUT;
      end
      ST_HICCUP: if (hic_done) state_next = ST_RUN;
      ST_THERM: if (flg[FLG_COOL] && !flg[FLG_HOT]) state_next = ST_RUN;
      ST_SSHUT: if (!flg[FLG_SS_LOW]) state_next = ST_RUN;
      default: state_next = ST_OFF;
    endcase
    if (flg[FLG_HOT] && state_reg != ST_OFF) state_next = ST_THERM;
    if (!por || !ctrl_en_reg) state_next = ST_OFF;
    hs_next = (state_next == ST_RUN) && (cyc_next < on_eff);
    ls_next = (state_next == ST_RUN) && !(cyc_next < on_eff);
    tri_next = !flg[FLG_EN] || state_next == ST_OFF;
    ssd_next = (state_next != ST_RUN) && (state_next != ST_SSHUT);
    ref_next = flg[FLG_TRACK];
    por_next = por;
    pg_next = pgd_done && pg_cond;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_OFF;
      cyc_reg <= '0;
      tick_reg <= 1'b0;
      blank_reg <= '0;
      ocp_reg <= 1'b0;
      pg_reg <= 1'b0;
      hs_gate <= 1'b0;
      ls_gate <= 1'b0;
      drv_tristate <= 1'b1;
      ss_discharge <= 1'b1;
      ref_internal <= 1'b0;
      undervoltage_lockout <= 1'b0;
      overcurrent_fault <= 1'b0;
      power_good_out_o <= 1'b0;
      power_good_out_oe <= 1'b1;
    end else begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
      tick_reg <= tick_next;
      blank_reg <= blank_next;
      ocp_reg <= ocp_next;
      pg_reg <= pg_next;
      hs_gate <= hs_next;
      ls_gate <= ls_next;
      drv_tristate <= tri_next;
      ss_discharge <= ssd_next;
      ref_internal <= ref_next;
      undervoltage_lockout <= por_next;
      overcurrent_fault <= ocp_next;
      power_good_out_o <= 1'b0;
      power_good_out_oe <= !pg_next;
    end
  end
endmodule : bfs_top

// ===== include/bfs_pkg.sv
// Shared constants for the buck fault and power-good sequencer.
// Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
package bfs_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;

  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] OFS_PERIOD = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] OFS_ONTIME = 8'h08;
  localparam logic [AXI_ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [AXI_ADDR_W-1:0] OFS_COUNT = 8'h10;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_KHZ = 125000;
  localparam int OFF_TIME_NS = 200;
  localparam int BLANK_TIME_NS = 160;
  localparam int FREQ_MIN_KHZ = 250;
  localparam int FREQ_MAX_KHZ = 1200;
  localparam int FREQ_RST_KHZ = 500;
  localparam int OFF_CYC = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HICCUP_CYCLES = 4096;
  localparam int PG_DELAY_CYCLES = 256;

  localparam int PER_W = 12;
  localparam logic [PER_W-1:0] PERIOD_MAX = PER_W'(CLK_KHZ / FREQ_MIN_KHZ);
  localparam logic [PER_W-1:0] PERIOD_MIN =
    PER_W'((CLK_KHZ + FREQ_MAX_KHZ - 1) / FREQ_MAX_KHZ);
  localparam logic [PER_W-1:0] PERIOD_RST = PER_W'(CLK_KHZ / FREQ_RST_KHZ);
  localparam logic [PER_W-1:0] OFF_CYC_W = PER_W'(OFF_CYC);
  localparam logic [PER_W-1:0] ONTIME_RST = 12'h040;
  localparam int BLANK_W = 6;
  localparam logic [BLANK_W-1:0] BLANK_CYC_W = BLANK_W'(BLANK_CYC);

  // Synchronised comparator flag positions
  localparam int FLG_BIAS = 0;
  localparam int FLG_EN = 1;
  localparam int FLG_SS_LOW = 2;
  localparam int FLG_OCSET = 3;
  localparam int FLG_LS_HIGH = 4;
  localparam int FLG_HOT = 5;
  localparam int FLG_COOL = 6;
  localparam int FLG_FB_HI = 7;
  localparam int FLG_FB_LO = 8;
  localparam int FLG_SS_PG = 9;
  localparam int FLG_TRACK = 10;
  localparam int FLG_PG_PIN = 11;
  localparam int FLG_N = 12;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_RUN = 5'b00010,
    ST_HICCUP = 5'b00100,
    ST_THERM = 5'b01000,
    ST_SSHUT = 5'b10000
  } bfs_state_type;
endpackage : bfs_pkg

// ===== hw/bfs_sync.sv
// Two-flop synchroniser for a vector of independent level inputs.
// Assumes each bit is a slow level; no bus coherency across bits.
`timescale 1ns/1ps
module bfs_sync #(
  parameter int W = 1
) (
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d;
    q_next = meta_reg;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= meta_next;
      q <= q_next;
    end
  end
endmodule : bfs_sync

// ===== hw/bfs_count.sv
// Saturating event counter with synchronous clear.
// Assumes tick is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module bfs_count #(
  parameter int W = 13,
  parameter int LIMIT = 4096
) (
  input wire logic core_clk, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic clr, // restart from zero
  input wire logic tick, // count one event
  output logic [W-1:0] count, // events counted
  output logic done // count reached LIMIT
);
  localparam logic [W-1:0] LIM = W'(LIMIT);
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count;
    if (clr) begin
      count_next = '0;
    end else if (tick && count != LIM) begin
      count_next = count + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= count_next;
    end
  end

  assign done = (count == LIM);
endmodule : bfs_count

// ===== verification/bfs_top_asserts.sv
// Concurrent checks on the ports of the buck supervisor top.
// Bound into every bfs_top; one clock domain, async active-low reset.
`timescale 1ns/1ps
module bfs_top_asserts
  import bfs_pkg::*;
#(
  parameter int HICCUP_N = 4096,
  parameter int PG_DELAY_N = 256
) (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset
  input wire logic bias_ok, // bias good
  input wire logic enable_ok, // enable good
  input wire logic ls_gate_high, // low gate up
  input wire logic temp_trip, // hot
  input wire logic feedback_input_high, // above window
  input wire logic feedback_input_low, // below window
  input wire logic track_handover, // tracking high
  input wire logic power_good_out_o, // pin value
  input wire logic power_good_out_oe, // pin pulled
  input wire logic undervoltage_lockout, // ready
  input wire logic drv_tristate, // drivers off
  input wire logic hs_gate, // high gate
  input wire logic ls_gate, // low gate
  input wire logic ss_discharge, // soft-start short
  input wire logic ref_internal, // internal ref
  input wire logic overcurrent_fault // latch
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  int ls_cnt_reg, ls_cnt_next, oc_cnt_reg, oc_cnt_next;
  // Run lengths of raw ls_gate_high and of overcurrent_fault; six-cycle windows cover sync plus register lag
  always_comb begin
    ls_cnt_next = ls_gate_high ? (ls_cnt_reg < 999 ? ls_cnt_reg + 1 : ls_cnt_reg) : 0;
    oc_cnt_next = overcurrent_fault ? oc_cnt_reg + 1 : 0;
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ls_cnt_reg <= 0;
      oc_cnt_reg <= 0;
    end else begin
      ls_cnt_reg <= ls_cnt_next;
      oc_cnt_reg <= oc_cnt_next;
    end
  end
  sequence s_out_win; (feedback_input_high || feedback_input_low) [*6]; endsequence
  sequence s_hot; temp_trip [*6]; endsequence
  property p_tristate; !enable_ok [*6] |-> drv_tristate; endproperty
  property p_por; (!bias_ok || !enable_ok) [*6] |-> !undervoltage_lockout; endproperty
  property p_off; !undervoltage_lockout [*2] |-> !hs_gate && !ls_gate; endproperty
  property p_blank; $rose(overcurrent_fault) |-> ls_cnt_reg >= BLANK_CYC; endproperty
  property p_hic_ss; overcurrent_fault [*3] |-> ss_discharge && !hs_gate && !ls_gate; endproperty
  property p_hic_len;
    $fell(overcurrent_fault) && undervoltage_lockout |-> oc_cnt_reg >= (HICCUP_N - 1) * PERIOD_MIN;
  endproperty
  property p_therm; s_hot |-> ss_discharge && !hs_gate && !ls_gate; endproperty
  property p_window; s_out_win |-> power_good_out_oe; endproperty
  property p_od; !power_good_out_o; endproperty
  property p_ref; track_handover [*6] |-> ref_internal; endproperty
  a_tristate: assert property (p_tristate) else $error("drivers not tristated");
  a_por: assert property (p_por) else $error("ready without supplies");
  a_off: assert property (p_off) else $error("gates on while not ready");
  a_blank: assert property (p_blank) else $error("fault inside blanking");
  a_hic_ss: assert property (p_hic_ss) else $error("hiccup not discharging");
  a_hic_len: assert property (p_hic_len) else $error("hiccup too short");
  a_therm: assert property (p_therm) else $error("hot but switching");
  a_window: assert property (p_window) else $error("good outside window");
  a_od: assert property (p_od) else $error("pin driven high");
  a_ref: assert property (p_ref) else $error("reference not internal");
endmodule : bfs_top_asserts
bind bfs_top bfs_top_asserts #(.HICCUP_N(HICCUP_N), .PG_DELAY_N(PG_DELAY_N)) u_chk (.*);

// ===== verification/bfs_host_model.sv
// Host side: brings up bias, enable and tracking in order, pulls power-good up.
// Request levels come from the bench; one clock.
`timescale 1ns/1ps
module bfs_host_model (
  input wire logic core_clk, // clock
  input wire logic bias_req, // want bias
  input wire logic en_req, // want enable
  input wire logic trk_req, // want tracking high
  input wire logic power_good_out_o, // device pin value
  input wire logic power_good_out_oe, // device pulls pin
  output logic bias_ok = 1'b0, // bias level
  output logic enable_ok = 1'b0, // enable level
  output logic track_handover = 1'b0, // tracking level
  output wire logic pg_pin // resolved pin
);
  // Each stage waits for the one before, so teardown also runs in order
  always @(posedge core_clk) begin
    bias_ok <= bias_req;
    enable_ok <= bias_ok && en_req;
    track_handover <= enable_ok && trk_req;
  end
  assign pg_pin = power_good_out_oe ? power_good_out_o : 1'b1;
endmodule : bfs_host_model

// ===== verification/tb_top.sv
// Self-checking bench for bfs_top with the host model on the supply side.
// Bench drives the register bus and the comparator flags other than bias, enable, tracking and the power-good pin (from the host model) at the rising edge.
`timescale 1ns/1ps
module tb_top;
  import bfs_pkg::*;
  localparam int HN = 8;
  localparam int PN = 4;
  logic core_clk, arst_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic bias_ok, enable_ok, ss_shutdown_low, ocset_below_gnd, ls_gate_high, temp_trip;
  logic temp_cool, feedback_input_high, feedback_input_low, ss_pg_ready, track_handover;
  logic power_good_out_i, power_good_out_o, power_good_out_oe, undervoltage_lockout;
  logic drv_tristate, hs_gate, ls_gate, ss_discharge, ref_internal, overcurrent_fault;
  logic bias_req, en_req, trk_req, g;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] pv[3], ev[3];
  int failures, n_compared, n, i, r;
  bfs_top #(.HICCUP_N(HN), .PG_DELAY_N(PN)) dut (.*);
  bfs_host_model host (
    .core_clk, .bias_req, .en_req, .trk_req, .power_good_out_o, .power_good_out_oe,
    .bias_ok, .enable_ok, .track_handover, .pg_pin(power_good_out_i)
  );
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input logic c, input string m);
    n_compared++;
    if (c !== 1'b1) begin
      failures++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask : chk
  task automatic tmo(input logic t);
    if (t) begin
      chk(1'b0, "timeout");
      finish_test();
    end
  endtask : tmo
  task automatic wt(ref logic s, input logic v, input int lim);
    for (n = 0; n < lim && s !== v; n++) @(posedge core_clk);
    tmo(n >= lim);
  endtask : wt
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    bq.push_back(RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50 && !(s_axi_bvalid && s_axi_bready); k++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    tmo(k >= 50);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] rs, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    rq.push_back({rs, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50 && !(s_axi_rvalid && s_axi_rready); k++) begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    tmo(k >= 50);
  endtask : axi_rd
  // Bus answers judged apart from the drivers
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk({s_axi_rresp, s_axi_rdata} === rq.pop_front(), "read data or response");
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      chk(s_axi_bresp === bq.pop_front(), "write response");
  end
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {ss_shutdown_low, ocset_below_gnd, ls_gate_high, temp_trip, ss_pg_ready} = '0;
    {feedback_input_high, feedback_input_low, bias_req, en_req, trk_req} = '0;
    temp_cool = 1'b1;
    failures = 0;
    n_compared = 0;
    r = $urandom(64);
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk(drv_tristate === 1'b1 && ss_discharge === 1'b1 && power_good_out_oe === 1'b1, "reset");
    axi_rd(OFS_CTRL, RESP_OKAY, 32'h00000001);
    axi_rd(OFS_PERIOD, RESP_OKAY, 32'(PERIOD_RST));
    axi_rd(8'h20, RESP_SLVERR, 32'h00000000);
    axi_rd(OFS_ONTIME, RESP_OKAY, 32'(ONTIME_RST));
    r = int'(PERIOD_MIN) + int'($urandom % (PERIOD_MAX - PERIOD_MIN + 1));
    pv = '{32'h00000014, 32'h00000FFF, 32'(r)};
    ev = '{32'(PERIOD_MIN), 32'(PERIOD_MAX), 32'(r)};
    for (i = 0; i < 3; i++) begin
      axi_wr(OFS_PERIOD, pv[i]);
      axi_rd(OFS_PERIOD, RESP_OKAY, ev[i]);
    end
    axi_wr(OFS_PERIOD, 32'(PERIOD_MIN));
    $display("test registers done");
    bias_req <= 1'b1;
    en_req <= 1'b1;
    trk_req <= 1'b1;
    wt(ss_discharge, 1'b0, 40);
    repeat (5) @(posedge core_clk);
    chk(undervoltage_lockout === 1'b1 && drv_tristate === 1'b0, "power up");
    chk(ss_discharge === 1'b0 && ref_internal === 1'b1, "start and reference");
    repeat (PN * 120) @(posedge core_clk);
    chk(power_good_out_oe === 1'b1, "good before soft-start level");
    ss_pg_ready <= 1'b1;
    wt(power_good_out_oe, 1'b0, PN * 600);
    chk(n >= (PN - 1) * 105 && power_good_out_i === 1'b1, "good delay");
    feedback_input_high <= 1'b1;
    wt(power_good_out_oe, 1'b1, 20);
    chk(power_good_out_i === 1'b0, "good out of window");
    feedback_input_high <= 1'b0;
    trk_req <= 1'b0;
    wt(ref_internal, 1'b0, 20);
    chk(ref_internal === 1'b0, "tracking follows input");
    trk_req <= 1'b1;
    $display("test power good done");
    ocset_below_gnd <= 1'b1;
    ls_gate_high <= 1'b1;
    repeat (10) @(posedge core_clk);
    ls_gate_high <= 1'b0;
    repeat (10) @(posedge core_clk);
    chk(overcurrent_fault === 1'b0, "sample inside blanking");
    ls_gate_high <= 1'b1;
    wt(overcurrent_fault, 1'b1, 60);
    chk(n >= 18 && overcurrent_fault === 1'b1, "over-current latch");
    repeat (3) @(posedge core_clk);
    chk(ss_discharge === 1'b1 && hs_gate === 1'b0, "hiccup discharge");
    wt(overcurrent_fault, 1'b0, HN * 600);
    chk(n >= (HN - 1) * 105 && n < HN * 600, "hiccup length");
    wt(overcurrent_fault, 1'b1, 100);
    chk(overcurrent_fault === 1'b1, "hiccup repeats");
    ocset_below_gnd <= 1'b0;
    wt(overcurrent_fault, 1'b0, HN * 600);
    repeat (200) @(posedge core_clk);
    chk(overcurrent_fault === 1'b0 && ss_discharge === 1'b0, "hiccup left");
    ls_gate_high <= 1'b0;
    $display("test over-current done");
    temp_trip <= 1'b1;
    temp_cool <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(ss_discharge === 1'b1 && hs_gate === 1'b0 && ls_gate === 1'b0, "thermal off");
    temp_trip <= 1'b0;
    repeat (20) @(posedge core_clk);
    chk(ss_discharge === 1'b1, "hysteresis band");
    temp_cool <= 1'b1;
    wt(ss_discharge, 1'b0, 20);
    chk(ss_discharge === 1'b0, "thermal restart");
    $display("test thermal done");
    ss_shutdown_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    g = 1'b0;
    repeat (300) begin
      @(posedge core_clk);
      g = g | hs_gate | ls_gate;
    end
    chk(g === 1'b0, "soft-start shutdown");
    ss_shutdown_low <= 1'b0;
    wt(hs_gate, 1'b1, 400);
    chk(hs_gate === 1'b1, "switching resumes");
    wt(hs_gate, 1'b0, 400);
    wt(hs_gate, 1'b1, 400);
    chk(n >= OFF_CYC - 1 && n < 400, "off time");
    $display("test shutdown done");
    en_req <= 1'b0;
    wt(drv_tristate, 1'b1, 20);
    chk(drv_tristate === 1'b1 && undervoltage_lockout === 1'b0, "enable off");
    $display("test enable done");
    finish_test();
  end
endmodule : tb_top
